// ---- hdl/bmu_bit_manip.sv ----
// Operation
// - Signed pull: range capped at 31, sign-extend
// - Unsigned pull: same range, zero above
// - Register pull: length rs2[9:5], start rs2[4:0]
// - Deposit rs1 low bits, other bits keep destination
// - Register deposit: rs2 fields, rest kept
// - Zero fill: range cleared, rest from rs1
// - One fill: range set, rest from rs1
// - Register fills take fields from rs2
// - Lowest set index, 32 for zero
// - Highest set index, 32 for zero
// - Leading sign bits minus one, zero gives 0
// - Population count of the first source
// - Reversal groups of 1, 2, 3 bits
// - Group select 3 acts as single bits
// - Immediate forms decoded on opcode 1011011
// - Register forms decoded on 0101011, funct3 011
// - Length field is bit count minus one
// - Reversal first shifts left by start position
// - Accepted only when extension enable is one
`timescale 1ns/10ps
`default_nettype none
module bmu_bit_manip #(
  parameter int unsigned CUSTOM_EXTENSION_ENABLE = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] rs1_i,
  input wire logic [31:0] rs2_i,
  input wire logic [31:0] rd_old_i,
  output logic op_claim_o,
  output logic result_valid_o,
  output logic [31:0] result_o
);

  generate
    if (CUSTOM_EXTENSION_ENABLE > 1) begin : g_bad_enable
      $error("CUSTOM_EXTENSION_ENABLE must be 0 or 1");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fields

  logic [6:0] opc;
  logic [2:0] f3;
  logic [6:0] f7;
  logic [1:0] immediate_subop_select;
  logic [4:0] imm_len;
  logic [4:0] imm_start;
  logic [4:0] rs2_field;
  logic is_imm_form;

  assign opc = instr_i[bmu_pkg::POS_OPC_LO +: 7];
  assign f3 = instr_i[bmu_pkg::POS_F3_LO +: 3];
  assign f7 = instr_i[bmu_pkg::POS_F7_LO +: 7];
  assign immediate_subop_select = instr_i[bmu_pkg::POS_SUBOP_LO +: 2];
  assign imm_len = instr_i[bmu_pkg::POS_LEN_LO +: 5];
  assign imm_start = instr_i[bmu_pkg::POS_START_LO +: 5];
  assign rs2_field = instr_i[bmu_pkg::POS_RS2_LO +: 5];
  assign is_imm_form = (opc == bmu_pkg::OPC_IMM_FIELD);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  bmu_pkg::bmu_op_t op;
  logic unary_ok;

  assign unary_ok = (rs2_field == bmu_pkg::RS2_UNARY);

  always_comb begin
    op = bmu_pkg::OP_NONE;
    if (CUSTOM_EXTENSION_ENABLE == 1) begin
      if (opc == bmu_pkg::OPC_IMM_FIELD && f3 == bmu_pkg::F3_IMM_PULL) begin
        case (immediate_subop_select)
          bmu_pkg::SUB_PULL_SIGNED: op = bmu_pkg::OP_PULL_SIGNED;
          bmu_pkg::SUB_PULL_UNSIGNED: op = bmu_pkg::OP_PULL_UNSIGNED;
          bmu_pkg::SUB_DEPOSIT: op = bmu_pkg::OP_DEPOSIT;
          default: op = bmu_pkg::OP_NONE;
        endcase
      end else if (opc == bmu_pkg::OPC_IMM_FIELD && f3 == bmu_pkg::F3_IMM_FILL) begin
        case (immediate_subop_select)
          bmu_pkg::SUB_ZERO_FILL: op = bmu_pkg::OP_ZERO_FILL;
          bmu_pkg::SUB_ONE_FILL: op = bmu_pkg::OP_ONE_FILL;
          bmu_pkg::SUB_REVERSAL: begin
            // Reversal length field carries only two bits
            if (imm_len[4:2] == bmu_pkg::REV_LEN_UPPER) begin
              op = bmu_pkg::OP_REVERSAL;
            end
          end
          default: op = bmu_pkg::OP_NONE;
        endcase
      end else if (opc == bmu_pkg::OPC_REG_FIELD && f3 == bmu_pkg::F3_REG_OPS) begin
        case (f7)
          bmu_pkg::F7_PULL_SIGNED: op = bmu_pkg::OP_PULL_SIGNED;
          bmu_pkg::F7_PULL_UNSIGNED: op = bmu_pkg::OP_PULL_UNSIGNED;
          bmu_pkg::F7_DEPOSIT: op = bmu_pkg::OP_DEPOSIT;
          bmu_pkg::F7_ZERO_FILL: op = bmu_pkg::OP_ZERO_FILL;
          bmu_pkg::F7_ONE_FILL: op = bmu_pkg::OP_ONE_FILL;
          bmu_pkg::F7_ROTATE: op = bmu_pkg::OP_ROTATE;
          bmu_pkg::F7_LOWEST_SET: op = unary_ok ? bmu_pkg::OP_LOWEST_SET : bmu_pkg::OP_NONE;
          bmu_pkg::F7_HIGHEST_SET: op = unary_ok ? bmu_pkg::OP_HIGHEST_SET : bmu_pkg::OP_NONE;
          bmu_pkg::F7_SIGN_COUNT: op = unary_ok ? bmu_pkg::OP_SIGN_COUNT : bmu_pkg::OP_NONE;
          bmu_pkg::F7_POP_COUNT: op = unary_ok ? bmu_pkg::OP_POP_COUNT : bmu_pkg::OP_NONE;
          default: op = bmu_pkg::OP_NONE;
        endcase
      end
    end
  end

  assign op_claim_o = instr_valid_i && (op != bmu_pkg::OP_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Field range

  logic [4:0] field_length_minus_one;
  logic [4:0] field_start_position;
  logic [5:0] range_sum;
  logic [4:0] range_top;
  logic [31:0] range_mask;
  logic [31:0] low_mask;

  // Register forms take both fields from the second source
  assign field_length_minus_one = is_imm_form ? imm_len : rs2_i[bmu_pkg::POS_RS2_LEN_LO +: 5];
  assign field_start_position = is_imm_form ? imm_start : rs2_i[bmu_pkg::POS_RS2_START_LO +: 5];
  // Field spans length field plus one bits, capped at the top bit
  assign range_sum = {1'b0, field_length_minus_one} + {1'b0, field_start_position};
  assign range_top = (range_sum > {1'b0, bmu_pkg::BIT_TOP}) ? bmu_pkg::BIT_TOP : range_sum[4:0];

  always_comb begin
    range_mask = '0;
    for (int i = 0; i < 32; i++) begin
      range_mask[i] = (5'(i) >= field_start_position) && (5'(i) <= range_top);
    end
  end

  assign low_mask = range_mask >> field_start_position;

  ////////////////////////////////////////////////////////////////////////////
  // Field operations

  logic [31:0] pulled;
  logic [31:0] pull_unsigned;
  logic [31:0] pull_signed;
  logic [31:0] deposit;
  logic [31:0] zero_fill;
  logic [31:0] one_fill;

  assign pulled = rs1_i >> field_start_position;
  assign pull_unsigned = pulled & low_mask;
  // Sign taken from the most significant pulled bit
  assign pull_signed = rs1_i[range_top] ? (pulled | ~low_mask) : pull_unsigned;
  // Bits beyond a capped range fall off; software keeps the sum below 32
  assign deposit = (rd_old_i & ~range_mask) | ((rs1_i << field_start_position) & range_mask);
  assign zero_fill = rs1_i & ~range_mask;
  assign one_fill = rs1_i | range_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Rotate and reversal

  logic [4:0] rot_amount;
  logic [63:0] rot_pair;
  logic [31:0] rotated;
  logic [31:0] reversed;

  assign rot_amount = rs2_i[4:0];
  assign rot_pair = {rs1_i, rs1_i} >> rot_amount;
  assign rotated = rot_pair[31:0];

  bmu_grouped_reversal u_reversal (
    .src_i(rs1_i),
    .field_start_position_i(imm_start),
    .group_select_i(imm_len[1:0]),
    .reversed_o(reversed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counting operations

  logic [5:0] lowest_idx;
  logic [5:0] highest_idx;
  logic [5:0] sign_run;
  logic [5:0] sign_count;
  logic [5:0] ones;
  logic run_open;

  always_comb begin
    lowest_idx = bmu_pkg::ZERO_SOURCE_INDEX;
    for (int i = 31; i >= 0; i--) begin
      if (rs1_i[i]) begin
        lowest_idx = 6'(i);
      end
    end
  end

  always_comb begin
    highest_idx = bmu_pkg::ZERO_SOURCE_INDEX;
    for (int i = 0; i < 32; i++) begin
      if (rs1_i[i]) begin
        highest_idx = 6'(i);
      end
    end
  end

  always_comb begin
    sign_run = 6'h00;
    run_open = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      if (run_open && (rs1_i[i] == rs1_i[31])) begin
        sign_run = sign_run + 6'h01;
      end else begin
        run_open = 1'b0;
      end
    end
  end

  // Zero source gives zero, otherwise run length minus one
  assign sign_count = (rs1_i == 32'h0000_0000) ? 6'h00 : (sign_run - 6'h01);

  always_comb begin
    ones = 6'h00;
    for (int i = 0; i < 32; i++) begin
      ones = ones + {5'h00, rs1_i[i]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result select and output register

  bmu_pkg::bmu_state_t state;
  bmu_pkg::bmu_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.valid = op_claim_o;
    if (op_claim_o) begin
      case (op)
        bmu_pkg::OP_PULL_SIGNED: next_state.result = pull_signed;
        bmu_pkg::OP_PULL_UNSIGNED: next_state.result = pull_unsigned;
        bmu_pkg::OP_DEPOSIT: next_state.result = deposit;
        bmu_pkg::OP_ZERO_FILL: next_state.result = zero_fill;
        bmu_pkg::OP_ONE_FILL: next_state.result = one_fill;
        bmu_pkg::OP_REVERSAL: next_state.result = reversed;
        bmu_pkg::OP_ROTATE: next_state.result = rotated;
        bmu_pkg::OP_LOWEST_SET: next_state.result = {26'h0, lowest_idx};
        bmu_pkg::OP_HIGHEST_SET: next_state.result = {26'h0, highest_idx};
        bmu_pkg::OP_SIGN_COUNT: next_state.result = {26'h0, sign_count};
        bmu_pkg::OP_POP_COUNT: next_state.result = {26'h0, ones};
        default: next_state.result = state.result;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state.valid <= bmu_pkg::RST_VALID;
      state.result <= bmu_pkg::RST_RESULT;
    end else begin
      state <= next_state;
    end
  end

  assign result_valid_o = state.valid;
  assign result_o = state.result;

endmodule
`default_nettype wire

// ---- hdl/bmu_pkg.sv ----
`default_nettype none
package bmu_pkg;

  localparam int unsigned XLEN = 32;

  // Major opcodes
  localparam logic [6:0] OPC_IMM_FIELD = 7'h5B;
  localparam logic [6:0] OPC_REG_FIELD = 7'h2B;

  // Instruction field positions
  localparam int unsigned POS_OPC_LO = 0;
  localparam int unsigned POS_F3_LO = 12;
  localparam int unsigned POS_RS2_LO = 20;
  localparam int unsigned POS_START_LO = 20;
  localparam int unsigned POS_LEN_LO = 25;
  localparam int unsigned POS_F7_LO = 25;
  localparam int unsigned POS_SUBOP_LO = 30;

  // Register operand layout of the second source
  localparam int unsigned POS_RS2_START_LO = 0;
  localparam int unsigned POS_RS2_LEN_LO = 5;

  // funct3 values
  localparam logic [2:0] F3_IMM_PULL = 3'h0;
  localparam logic [2:0] F3_IMM_FILL = 3'h1;
  localparam logic [2:0] F3_REG_OPS = 3'h3;

  // Immediate sub-op values
  localparam logic [1:0] SUB_PULL_SIGNED = 2'h0;
  localparam logic [1:0] SUB_PULL_UNSIGNED = 2'h1;
  localparam logic [1:0] SUB_DEPOSIT = 2'h2;
  localparam logic [1:0] SUB_ZERO_FILL = 2'h0;
  localparam logic [1:0] SUB_ONE_FILL = 2'h1;
  localparam logic [1:0] SUB_REVERSAL = 2'h3;

  // funct7 values of the register forms
  localparam logic [6:0] F7_PULL_SIGNED = 7'h18;
  localparam logic [6:0] F7_PULL_UNSIGNED = 7'h19;
  localparam logic [6:0] F7_DEPOSIT = 7'h1A;
  localparam logic [6:0] F7_ZERO_FILL = 7'h1C;
  localparam logic [6:0] F7_ONE_FILL = 7'h1D;
  localparam logic [6:0] F7_ROTATE = 7'h20;
  localparam logic [6:0] F7_LOWEST_SET = 7'h21;
  localparam logic [6:0] F7_HIGHEST_SET = 7'h22;
  localparam logic [6:0] F7_SIGN_COUNT = 7'h23;
  localparam logic [6:0] F7_POP_COUNT = 7'h24;

  localparam logic [4:0] RS2_UNARY = 5'h00;
  localparam logic [2:0] REV_LEN_UPPER = 3'h0;
  localparam logic [4:0] BIT_TOP = 5'h1F;
  localparam logic [5:0] ZERO_SOURCE_INDEX = 6'h20;

  // Group-select codes of the reversal
  localparam logic [1:0] GRP_SINGLE = 2'h0;
  localparam logic [1:0] GRP_PAIR = 2'h1;
  localparam logic [1:0] GRP_TRIPLE = 2'h2;

  // Reset values
  localparam logic [31:0] RST_RESULT = 32'h0000_0000;
  localparam logic RST_VALID = 1'b0;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_PULL_SIGNED = 4'b0001,
    OP_PULL_UNSIGNED = 4'b0010,
    OP_DEPOSIT = 4'b0011,
    OP_ZERO_FILL = 4'b0100,
    OP_ONE_FILL = 4'b0101,
    OP_REVERSAL = 4'b0110,
    OP_ROTATE = 4'b0111,
    OP_LOWEST_SET = 4'b1000,
    OP_HIGHEST_SET = 4'b1001,
    OP_SIGN_COUNT = 4'b1010,
    OP_POP_COUNT = 4'b1011
  } bmu_op_t;

  typedef struct packed {
    logic valid;
    logic [31:0] result;
  } bmu_state_t;

endpackage
`default_nettype wire

// ---- hdl/bmu_grouped_reversal.sv ----
`timescale 1ns/10ps
`default_nettype none
module bmu_grouped_reversal (
  input wire logic [31:0] src_i,
  input wire logic [4:0] field_start_position_i,
  input wire logic [1:0] group_select_i,
  output logic [31:0] reversed_o
);

  logic [31:0] shifted;
  logic [31:0] rev_single;
  logic [31:0] rev_pair;
  logic [31:0] rev_triple;

  // Top bits are dropped so only the low part takes part
  assign shifted = src_i << field_start_position_i;

  genvar k;
  generate
    for (k = 0; k < 32; k++) begin : g_single
      assign rev_single[k] = shifted[31 - k];
    end
    for (k = 0; k < 16; k++) begin : g_pair
      assign rev_pair[2 * k + 1 : 2 * k] = shifted[31 - 2 * k : 30 - 2 * k];
    end
    // Ten triples fill bits 29:0; the two lowest shifted bits are lost
    for (k = 0; k < 10; k++) begin : g_triple
      assign rev_triple[3 * k + 2 : 3 * k] = shifted[31 - 3 * k : 29 - 3 * k];
    end
  endgenerate
  assign rev_triple[31:30] = 2'h0;

  always_comb begin
    case (group_select_i)
      bmu_pkg::GRP_PAIR: reversed_o = rev_pair;
      bmu_pkg::GRP_TRIPLE: reversed_o = rev_triple;
      default: reversed_o = rev_single;
    endcase
  end

endmodule
`default_nettype wire

// ---- test/bmu_bit_manip_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module bmu_bit_manip_monitor #(
  parameter int unsigned CUSTOM_EXTENSION_ENABLE = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] rs1_i,
  input wire logic [31:0] rs2_i,
  input wire logic [31:0] rd_old_i,
  input wire logic op_claim_o,
  input wire logic result_valid_o,
  input wire logic [31:0] result_o
);
  logic reg_op;
  logic rev_op;
  logic [6:0] f7;
  logic [4:0] rot_amt;
  assign f7 = instr_i[31:25];
  assign rot_amt = rs2_i[4:0];
  assign reg_op = instr_valid_i && instr_i[6:0] == bmu_pkg::OPC_REG_FIELD && instr_i[14:12] == bmu_pkg::F3_REG_OPS;
  assign rev_op = instr_valid_i && instr_i[6:0] == bmu_pkg::OPC_IMM_FIELD && instr_i[14:12] == bmu_pkg::F3_IMM_FILL
    && instr_i[31:30] == bmu_pkg::SUB_REVERSAL;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_claim_answers: assert property (op_claim_o |=> result_valid_o)
    else $error("claim without result pulse");
  a_idle_silent: assert property (!op_claim_o |=> !result_valid_o && $stable(result_o))
    else $error("result moved without a claim");
  a_claim_needs_valid: assert property (op_claim_o |-> instr_valid_i)
    else $error("claim without valid instruction");
  a_rev_upper_refused: assert property (rev_op && instr_i[29:27] != bmu_pkg::REV_LEN_UPPER |-> !op_claim_o)
    else $error("reversal with upper length bits claimed");
  a_unary_rs2_refused: assert property (reg_op && f7 inside {[bmu_pkg::F7_LOWEST_SET:bmu_pkg::F7_POP_COUNT]}
    && instr_i[24:20] != bmu_pkg::RS2_UNARY |-> !op_claim_o) else $error("unary op with rs2 field claimed");
  a_rotate_decode: assert property (CUSTOM_EXTENSION_ENABLE == 1 && reg_op && f7 == bmu_pkg::F7_ROTATE |-> op_claim_o)
    else $error("rotate not claimed");
  a_rotate_value: assert property (op_claim_o && reg_op && f7 == bmu_pkg::F7_ROTATE |=>
    result_o == (($past(rs1_i) >> $past(rot_amt)) | ($past(rs1_i) << (6'h20 - $past(rot_amt)))))
    else $error("rotate result wrong");
  a_pop_value: assert property (op_claim_o && reg_op && f7 == bmu_pkg::F7_POP_COUNT |=>
    result_o == 32'($countones($past(rs1_i)))) else $error("population count wrong");
  a_lowest_zero: assert property (op_claim_o && reg_op && f7 == bmu_pkg::F7_LOWEST_SET && rs1_i == 32'h0 |=>
    result_o == {26'h0, bmu_pkg::ZERO_SOURCE_INDEX}) else $error("lowest index of zero wrong");
  a_highest_top: assert property (op_claim_o && reg_op && f7 == bmu_pkg::F7_HIGHEST_SET && rs1_i[31] |=>
    result_o == 32'h1F) else $error("highest index of top bit wrong");
endmodule
bind bmu_bit_manip bmu_bit_manip_monitor #(.CUSTOM_EXTENSION_ENABLE(CUSTOM_EXTENSION_ENABLE)) u_mon (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .rs1_i(rs1_i),
  .rs2_i(rs2_i), .rd_old_i(rd_old_i), .op_claim_o(op_claim_o), .result_valid_o(result_valid_o), .result_o(result_o));
`default_nettype wire

// ---- test/bmu_issue_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module bmu_issue_model (
  input wire logic ref_clk_i,
  output logic instr_valid_o,
  output logic [31:0] instr_o,
  output logic [31:0] rs1_o,
  output logic [31:0] rs2_o,
  output logic [31:0] rd_old_o
);
  initial begin
    instr_valid_o = 1'b0;
    instr_o = 32'h0;
    rs1_o = 32'h0;
    rs2_o = 32'h0;
    rd_old_o = 32'h0;
  end
  // Idle cycles show inverted operands so stale values cannot pass
  task automatic issue(input logic v, input logic [31:0] ins, a, b, d);
    @(posedge ref_clk_i);
    #1;
    instr_valid_o = v;
    instr_o = ins;
    rs1_o = v ? a : ~a;
    rs2_o = v ? b : ~b;
    rd_old_o = v ? d : ~d;
  endtask
endmodule
`default_nettype wire

// ---- test/bmu_bit_manip_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module bmu_bit_manip_test;
  typedef struct packed {
    logic [31:0] ins;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] d;
    logic [31:0] e;
  } bmu_row_t;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic instr_valid_i, op_claim_o, result_valid_o, off_claim, off_valid;
  logic [31:0] instr_i, rs1_i, rs2_i, rd_old_i, result_o, off_result;
  int err_total = 0;
  int comparisons = 0;
  bmu_row_t rows[$];
  always #10 ref_clk_i = ~ref_clk_i;
  bmu_issue_model pm (.ref_clk_i(ref_clk_i), .instr_valid_o(instr_valid_i), .instr_o(instr_i), .rs1_o(rs1_i),
    .rs2_o(rs2_i), .rd_old_o(rd_old_i));
  bmu_bit_manip dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .rs1_i(rs1_i), .rs2_i(rs2_i), .rd_old_i(rd_old_i), .op_claim_o(op_claim_o), .result_valid_o(result_valid_o),
    .result_o(result_o));
  bmu_bit_manip #(.CUSTOM_EXTENSION_ENABLE(0)) dut_off (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .rs1_i(rs1_i), .rs2_i(rs2_i), .rd_old_i(rd_old_i),
    .op_claim_o(off_claim), .result_valid_o(off_valid), .result_o(off_result));
  function automatic logic [31:0] im(input logic [1:0] s, input logic [2:0] f, input logic [4:0] l, st);
    return {s, l, st, 5'h00, f, 5'h00, bmu_pkg::OPC_IMM_FIELD};
  endfunction
  function automatic logic [31:0] rg(input logic [6:0] f, input logic [4:0] r2);
    return {f, r2, 5'h00, bmu_pkg::F3_REG_OPS, 5'h00, bmu_pkg::OPC_REG_FIELD};
  endfunction
  task automatic check(input string n, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic add(input logic [31:0] ins, a, b, d, e);
    rows.push_back('{ins, a, b, d, e});
  endtask
  // Refused request: no claim, no pulse, result unchanged
  task automatic refuse(input logic v, input logic [31:0] ins, last);
    pm.issue(v, ins, 32'h5, 32'h5, 32'h5);
    #1;
    check("claim", {31'h0, op_claim_o}, 32'h0);
    @(posedge ref_clk_i);
    #2;
    check("pulse", {31'h0, result_valid_o}, 32'h0);
    check("held", result_o, last);
  endtask
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial begin
    add(im(2'h0, 3'h0, 5'h03, 5'h04), 32'hA0, 32'h0, 32'h0, 32'hFFFFFFFA);
    add(im(2'h0, 3'h0, 5'h07, 5'h1C), 32'h80000000, 32'h0, 32'h0, 32'hFFFFFFF8);
    add(im(2'h1, 3'h0, 5'h03, 5'h04), 32'hA0, 32'h0, 32'h0, 32'hA);
    add(im(2'h1, 3'h0, 5'h07, 5'h1C), 32'h80000000, 32'h0, 32'h0, 32'h8);
    add(rg(7'h18, 5'h02), 32'hA0, 32'h64, 32'h0, 32'hFFFFFFFA);
    add(rg(7'h19, 5'h02), 32'hA0, 32'h64, 32'h0, 32'hA);
    add(im(2'h2, 3'h0, 5'h07, 5'h08), 32'h123456AB, 32'h0, 32'hFFFFFFFF, 32'hFFFFABFF);
    add(rg(7'h1A, 5'h02), 32'h123456AB, 32'hE8, 32'h0, 32'hAB00);
    add(im(2'h0, 3'h1, 5'h03, 5'h04), 32'hFFFFFFFF, 32'h0, 32'h0, 32'hFFFFFF0F);
    add(im(2'h1, 3'h1, 5'h07, 5'h1C), 32'h0, 32'h0, 32'h0, 32'hF0000000);
    add(rg(7'h1C, 5'h02), 32'hFFFFFFFF, 32'h64, 32'h0, 32'hFFFFFF0F);
    add(rg(7'h1D, 5'h02), 32'h0, 32'h64, 32'h0, 32'hF0);
    add(rg(7'h20, 5'h02), 32'h1, 32'h21, 32'h0, 32'h80000000);
    add(rg(7'h20, 5'h02), 32'h3, 32'h0, 32'h0, 32'h3);
    add(rg(7'h21, 5'h00), 32'h0, 32'h0, 32'h0, 32'h20);
    add(rg(7'h21, 5'h00), 32'h80000000, 32'h0, 32'h0, 32'h1F);
    add(rg(7'h21, 5'h00), 32'h1, 32'h0, 32'h0, 32'h0);
    add(rg(7'h22, 5'h00), 32'h0, 32'h0, 32'h0, 32'h20);
    add(rg(7'h22, 5'h00), 32'h80000001, 32'h0, 32'h0, 32'h1F);
    add(rg(7'h22, 5'h00), 32'h1, 32'h0, 32'h0, 32'h0);
    add(rg(7'h23, 5'h00), 32'h0, 32'h0, 32'h0, 32'h0);
    add(rg(7'h23, 5'h00), 32'hFFFFFFFF, 32'h0, 32'h0, 32'h1F);
    add(rg(7'h23, 5'h00), 32'hFFFF, 32'h0, 32'h0, 32'hF);
    add(rg(7'h23, 5'h00), 32'h80000000, 32'h0, 32'h0, 32'h0);
    add(rg(7'h24, 5'h00), 32'hC64A5933, 32'h0, 32'h0, 32'hF);
    add(im(2'h3, 3'h1, 5'h02, 5'h04), 32'hC64A5933, 32'h0, 32'h0, 32'h216B244B);
    add(im(2'h3, 3'h1, 5'h00, 5'h00), 32'h1, 32'h0, 32'h0, 32'h80000000);
    add(im(2'h3, 3'h1, 5'h01, 5'h00), 32'h1, 32'h0, 32'h0, 32'h40000000);
    add(im(2'h3, 3'h1, 5'h03, 5'h00), 32'h1, 32'h0, 32'h0, 32'h80000000);
    add(im(2'h3, 3'h1, 5'h00, 5'h04), 32'h10000001, 32'h0, 32'h0, 32'h08000000);
    repeat (5) @(posedge ref_clk_i);
    #1;
    check("rst_valid", {31'h0, result_valid_o}, 32'h0);
    check("rst_result", result_o, bmu_pkg::RST_RESULT);
    repeat (5) @(posedge ref_clk_i);
    #1 rst_b_i = 1'b1;
    for (int i = 0; i <= rows.size(); i++) begin
      if (i < rows.size()) begin
        pm.issue(1'b1, rows[i].ins, rows[i].a, rows[i].b, rows[i].d);
      end else begin
        pm.issue(1'b0, 32'h0, 32'h0, 32'h0, 32'h0);
      end
      #1;
      if (i > 0) begin
        check("valid", {31'h0, result_valid_o}, 32'h1);
        check("result", result_o, rows[i - 1].e);
      end
      if (i < rows.size()) begin
        check("claim", {31'h0, op_claim_o}, 32'h1);
        check("off_claim", {31'h0, off_claim}, 32'h0);
      end
    end
    refuse(1'b1, rg(7'h21, 5'h01), 32'h08000000);
    refuse(1'b1, im(2'h3, 3'h1, 5'h04, 5'h00), 32'h08000000);
    refuse(1'b1, 32'h00000033, 32'h08000000);
    refuse(1'b0, rg(7'h24, 5'h00), 32'h08000000);
    check("off_valid", {31'h0, off_valid}, 32'h0);
    pm.issue(1'b1, rg(7'h24, 5'h00), 32'hFF, 32'h0, 32'h0);
    @(posedge ref_clk_i);
    #1;
    check("pre_rst_result", result_o, 32'h8);
    rst_b_i = 1'b0;
    #1;
    check("mid_rst_valid", {31'h0, result_valid_o}, 32'h0);
    check("mid_rst_result", result_o, bmu_pkg::RST_RESULT);
    @(posedge ref_clk_i);
    #1 rst_b_i = 1'b1;
    // The held request is taken at the first edge after release
    @(posedge ref_clk_i);
    #2;
    check("post_rst_valid", {31'h0, result_valid_o}, 32'h1);
    check("post_rst_result", result_o, 32'h8);
    end_of_test();
  end
endmodule
`default_nettype wire
